/* File: design/shsr_params.svh */
/*
 * Constants for the serial host port pin control block.
 * Assumes inclusion by the package and the design modules only.
 */
`ifndef SHSR_PARAMS_SVH
`define SHSR_PARAMS_SVH
`define SHSR_SYNC_STAGES 2
`define SHSR_ADDR_WIDTH 7
`define SHSR_ADDR_LOWER_BIT 0
`define SHSR_ADDR_UPPER_BIT 2
`define SHSR_REQ_MODE_OFF 2'h0
`endif

/* File: design/shsr_pkg.sv */
/*
 * Types of the serial host port pin control block.
 * Assumes the params header is on the include path.
 */
`include "shsr_params.svh"
package shsr_pkg;
    typedef enum logic [1:0] {
        shsr_idle,
        shsr_wait_req,
        shsr_busy,
        shsr_wait_release
    } shsr_state_type;

    typedef struct packed {
        shsr_state_type state;
        logic           req_out;
        logic           bus_error;
        logic           word_start;
        logic           sck_last;
        logic           miso_bit;
        logic           miso_oe_n;
        logic           req_oe_n;
        logic           miso_sample;
    } shsr_regs_type;
endpackage

/* File: design/shsr_sync.sv */
/*
 * Two-stage synchroniser for one level from outside the clock domain.
 * Assumes the input may change at any time relative to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module shsr_sync #(
    parameter logic RESET_VALUE = 1'b1
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic async_in,
    output var  logic sync_out
);
    logic first_stage;

    // First stage feeds only the second one
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            first_stage <= RESET_VALUE;
            sync_out    <= RESET_VALUE;
        end else begin
            first_stage <= async_in;
            sync_out    <= first_stage;
        end
    end
endmodule // shsr_sync
`default_nettype wire

/* File: design/shsr_pin_ctrl.sv */
/*
 * Pin control of the serial host port: slave select, address straps,
 * host request handshake and MISO direction.
 * Assumes a shift engine on clk_sys that reports word progress, and
 * pins resolved outside from the output enables (low = driving).
 */
`timescale 1ns/1ps
`default_nettype none
`include "shsr_params.svh"
module shsr_pin_ctrl
    import shsr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        soft_reset,
    input  wire logic        port_reset,
    input  wire logic        mode_i2c,
    input  wire logic        mode_master,
    input  wire logic [1:0]  request_mode_field,
    input  wire logic        bus_error_clear,
    input  wire logic        engine_ready,
    input  wire logic        engine_word_done,
    input  wire logic        engine_miso_bit,
    input  wire logic [4:0]  own_addr_base,
    input  wire logic        slave_select_n,
    input  wire logic        sck_pin,
    input  wire logic        i2c_addr_strap_upper,
    input  wire logic        i2c_addr_strap_lower,
    input  wire logic        host_request_n_in,
    output logic             host_request_n_out,
    output logic             host_request_n_oe_n,
    input  wire logic        miso_in,
    output logic             miso_out,
    output logic             miso_oe_n,
    output logic             slave_selected,
    output logic             sck_rise,
    output logic             master_word_start,
    output logic             master_miso_sample,
    output logic [6:0]       own_slave_addr,
    output logic             bus_error
);
    shsr_regs_type r;
    shsr_regs_type next_r;
    logic ss_n_sync;
    logic sck_sync;
    logic req_n_sync;
    logic miso_sync;
    logic any_reset;
    logic spi_slave;
    logic sck_edge;
    logic strap_upper_sync;
    logic strap_lower_sync;

    // Pin inputs pass two flops before any logic reads them
    shsr_sync #(.RESET_VALUE(1'b1)) u_sync_ss (
        .clk_sys (clk_sys),
        .reset   (reset),
        .async_in(slave_select_n),
        .sync_out(ss_n_sync)
    );
    shsr_sync #(.RESET_VALUE(1'b1)) u_sync_req (
        .clk_sys (clk_sys),
        .reset   (reset),
        .async_in(host_request_n_in),
        .sync_out(req_n_sync)
    );
    shsr_sync #(.RESET_VALUE(1'b0)) u_sync_sck (
        .clk_sys (clk_sys),
        .reset   (reset),
        .async_in(sck_pin),
        .sync_out(sck_sync)
    );
    shsr_sync #(.RESET_VALUE(1'b0)) u_sync_miso (
        .clk_sys (clk_sys),
        .reset   (reset),
        .async_in(miso_in),
        .sync_out(miso_sync)
    );
    shsr_sync #(.RESET_VALUE(1'b0)) u_sync_strap_upper (
        .clk_sys (clk_sys),
        .reset   (reset),
        .async_in(i2c_addr_strap_upper),
        .sync_out(strap_upper_sync)
    );
    shsr_sync #(.RESET_VALUE(1'b0)) u_sync_strap_lower (
        .clk_sys (clk_sys),
        .reset   (reset),
        .async_in(i2c_addr_strap_lower),
        .sync_out(strap_lower_sync)
    );

    assign any_reset = soft_reset | port_reset;
    assign spi_slave = !mode_i2c && !mode_master;
    assign sck_edge  = sck_sync && !r.sck_last;

    always_comb begin
        next_r = r;
        next_r.sck_last    = sck_sync;
        next_r.word_start  = 1'b0;
        next_r.miso_sample = miso_sync;
        // Software clear loses to a new error in the same cycle
        if (bus_error_clear) begin
            next_r.bus_error = 1'b0;
        end
        if (!mode_i2c && mode_master && !ss_n_sync) begin
            next_r.bus_error = 1'b1;
        end
        case (r.state)
            shsr_idle: begin
                next_r.req_out = 1'b0;
                if (!mode_master && engine_ready) begin
                    next_r.req_out = 1'b1;
                    next_r.state   = shsr_busy;
                end else if (mode_master) begin
                    next_r.state = shsr_wait_req;
                end
            end
            shsr_busy: begin
                // Slave: hold request until first clock of the word
                if (mode_master) begin
                    // Master parks here until the request is released
                    next_r.req_out = 1'b0;
                    if (req_n_sync) begin
                        next_r.state = shsr_idle;
                    end
                end else if (spi_slave && !ss_n_sync && sck_edge) begin
                    next_r.req_out = 1'b0;
                    next_r.state   = shsr_wait_release;
                end else if (mode_i2c && sck_edge) begin
                    next_r.req_out = 1'b0;
                    next_r.state   = shsr_wait_release;
                end
            end
            shsr_wait_req: begin
                if (!mode_master) begin
                    next_r.state = shsr_idle;
                end else if (!req_n_sync) begin
                    next_r.word_start = 1'b1;
                    next_r.state      = shsr_wait_release;
                end
            end
            shsr_wait_release: begin
                // Master also needs request released before next word
                if (engine_word_done) begin
                    if (mode_master && !req_n_sync) begin
                        next_r.state = shsr_busy;
                    end else begin
                        next_r.state = shsr_idle;
                    end
                end
            end
            default: begin
                next_r.state = shsr_idle;
            end
        endcase
        if (mode_master && r.state == shsr_idle && !req_n_sync) begin
            next_r.state = shsr_wait_req;
        end
        next_r.req_oe_n = !(!mode_master &&
            request_mode_field != `SHSR_REQ_MODE_OFF);
        next_r.miso_oe_n = !(spi_slave && !ss_n_sync);
        next_r.miso_bit  = engine_miso_bit;
        if (any_reset) begin
            next_r.state     = shsr_idle;
            next_r.req_out   = 1'b0;
            next_r.req_oe_n  = 1'b1;
            next_r.miso_oe_n = 1'b1;
            next_r.word_start = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            r <= '{state: shsr_idle, req_out: 1'b0, bus_error: 1'b0,
                   word_start: 1'b0, sck_last: 1'b0, miso_bit: 1'b0,
                   miso_oe_n: 1'b1, req_oe_n: 1'b1,
                   miso_sample: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // Request only drives while enabled; in master role it is an input
    assign host_request_n_out  = !r.req_out;
    assign host_request_n_oe_n = r.req_oe_n || reset;
    assign miso_out            = r.miso_bit;
    assign miso_oe_n           = r.miso_oe_n || reset;
    assign slave_selected      = spi_slave && !ss_n_sync;
    // Clock edges are ignored while deselected in SPI slave mode only
    assign sck_rise = sck_edge && (mode_i2c || mode_master ||
                                   !ss_n_sync);
    assign master_word_start  = r.word_start;
    assign master_miso_sample = r.miso_sample;
    assign bus_error          = r.bus_error;

    // Straps are plain inputs, never driven; only I2C slave reads them
    always_comb begin
        own_slave_addr = {own_addr_base, 2'h0};
        if (mode_i2c && !mode_master && !reset && !any_reset) begin
            own_slave_addr[`SHSR_ADDR_UPPER_BIT] =
                strap_upper_sync;
            own_slave_addr[`SHSR_ADDR_LOWER_BIT] =
                strap_lower_sync;
        end else begin
            own_slave_addr[`SHSR_ADDR_UPPER_BIT] = 1'b0;
            own_slave_addr[`SHSR_ADDR_LOWER_BIT] = 1'b0;
        end
    end
endmodule // shsr_pin_ctrl
`default_nettype wire

/* File: testbench/shsr_monitor.sv */
/* Checker of the host port pin control outputs.
   Assumes binding into shsr_pin_ctrl and modes held within a scenario. */
`timescale 1ns/1ps
`default_nettype none
module shsr_monitor (
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire logic       soft_reset,
    input wire logic       port_reset,
    input wire logic       mode_i2c,
    input wire logic       mode_master,
    input wire logic [1:0] request_mode_field,
    input wire logic       bus_error_clear,
    input wire logic       slave_select_n,
    input wire logic       host_request_n_out,
    input wire logic       host_request_n_oe_n,
    input wire logic       miso_oe_n,
    input wire logic       sck_rise,
    input wire logic       bus_error
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire logic any_rst = soft_reset || port_reset;
    wire logic spi_slv = !mode_master && !mode_i2c;
    AST_RESET_HIZ: assert property (disable iff (1'b0) reset ##1 reset |->
        host_request_n_oe_n && miso_oe_n && !bus_error) else $error("reset");
    AST_SOFT_HIZ: assert property (any_rst |=>
        host_request_n_oe_n && miso_oe_n) else $error("soft reset");
    AST_MODE_OFF: assert property (request_mode_field == 2'h0 ##1
        request_mode_field == 2'h0 |-> host_request_n_oe_n) else $error("off");
    AST_SEL_DRIVE: assert property ((spi_slv && !slave_select_n
        && !any_rst) [*4] |-> !miso_oe_n) else $error("select");
    AST_DESEL: assert property ((spi_slv && slave_select_n) [*4] |->
        miso_oe_n && !sck_rise) else $error("deselect");
    AST_BUS_ERR: assert property ((mode_master && !mode_i2c
        && !slave_select_n && !bus_error_clear) [*4] |-> bus_error)
        else $error("bus error");
    AST_STICKY: assert property (bus_error && !bus_error_clear
        && !any_rst |=> bus_error) else $error("sticky");
    AST_REQ_DROP: assert property (!mode_master && sck_rise |=>
        host_request_n_out) else $error("request drop");
    cover property (!host_request_n_oe_n && !host_request_n_out);
    cover property ($rose(bus_error));
    cover property (sck_rise ##1 host_request_n_out);
endmodule // shsr_monitor
bind shsr_pin_ctrl shsr_monitor u_shsr_monitor (.*);
`default_nettype wire

/* File: testbench/shsr_partner.sv */
/* Far-side SPI controller model: select, clock, request and MISO pins.
   Assumes a pull-up on the request pin and calls from the bench. */
`timescale 1ns/1ps
`default_nettype none
module shsr_partner (
    input  wire logic clk_sys,
    input  wire logic host_request_n_out,
    input  wire logic host_request_n_oe_n,
    input  wire logic miso_out,
    input  wire logic miso_oe_n,
    output var  logic slave_select_n = 1'b1,
    output var  logic sck_pin = 1'b0,
    output wire logic host_request_n_in,
    output wire logic miso_in
);
    logic req_drive = 1'b0;
    logic pat = 1'b0;
    // Pull-up decides the request pin when nobody drives it
    assign host_request_n_in = !host_request_n_oe_n ? host_request_n_out
                                                    : !req_drive;
    // Released MISO toggles so a stale value never looks valid
    always @(posedge clk_sys) pat <= ~pat;
    assign miso_in = !miso_oe_n ? miso_out : pat;
    // Clock stands still outside frames; 160 ns period inside
    task automatic pulses(input int n);
        repeat (2 * n) begin
            repeat (16) @(posedge clk_sys);
            sck_pin <= ~sck_pin;
        end
    endtask
endmodule // shsr_partner
`default_nettype wire

/* File: testbench/shsr_pin_ctrl_tb.sv */
/* Bench of the host port pin control: slave, master, errors, resets.
   Assumes the partner model on the pins and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module shsr_pin_ctrl_tb;
    logic       clk_sys = 1'b0;
    logic       reset = 1'b1;
    logic       soft_reset = 1'b0;
    logic       port_reset = 1'b0;
    logic       mode_i2c = 1'b0;
    logic       mode_master = 1'b0;
    logic [1:0] request_mode_field = 2'h1;
    logic       bus_error_clear = 1'b0;
    logic       engine_ready = 1'b0;
    logic       engine_word_done = 1'b0;
    logic       engine_miso_bit = 1'b1;
    logic [4:0] own_addr_base = 5'h15;
    logic       i2c_addr_strap_upper = 1'b0;
    logic       i2c_addr_strap_lower = 1'b0;
    wire logic  slave_select_n, sck_pin, host_request_n_in, miso_in, miso_out;
    wire logic  host_request_n_out, host_request_n_oe_n, miso_oe_n, bus_error;
    wire logic  slave_selected, sck_rise, master_word_start, master_miso_sample;
    wire logic [6:0] own_slave_addr;
    int         fails = 0;
    int         comparisons = 0;
    int         cycles = 0;
    shsr_pin_ctrl u_shsr_pin_ctrl (.*);
    shsr_partner  u_shsr_partner (.*);
    initial forever #2.5 clk_sys = ~clk_sys;
    task automatic chk(input string n, input logic [6:0] e, input logic [6:0] s);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic starts(input int n, input int e);
        int s = 0;
        repeat (n) begin
            @(negedge clk_sys);
            s += (master_word_start === 1'b1);
        end
        chk("word starts", 7'(e), 7'(s));
    endtask
    task automatic done_pulse;
        cyc(1);
        engine_word_done <= 1'b1;
        cyc(1);
        engine_word_done <= 1'b0;
    endtask
    task automatic t_slave;
        cyc(1);
        u_shsr_partner.slave_select_n <= 1'b0;
        engine_ready <= 1'b1;
        look(6);
        chk("request", 7'h0, host_request_n_out);
        chk("request oe", 7'h0, host_request_n_oe_n);
        chk("miso oe", 7'h0, miso_oe_n);
        chk("selected", 7'h1, slave_selected);
        chk("miso out", 7'h1, miso_out);
        cyc(1);
        engine_ready <= 1'b0;
        u_shsr_partner.pulses(1);
        look(1);
        chk("request", 7'h1, host_request_n_out);
        done_pulse();
        u_shsr_partner.slave_select_n <= 1'b1;
        request_mode_field <= 2'h0;
        u_shsr_partner.pulses(1);
        look(1);
        chk("miso oe", 7'h1, miso_oe_n);
        chk("request oe", 7'h1, host_request_n_oe_n);
    endtask
    task automatic t_master;
        cyc(1);
        request_mode_field <= 2'h1;
        mode_master <= 1'b1;
        engine_ready <= 1'b1;
        look(4);
        chk("request oe", 7'h1, host_request_n_oe_n);
        cyc(1);
        u_shsr_partner.req_drive <= 1'b1;
        starts(12, 1);
        done_pulse();
        starts(20, 0);
        cyc(1);
        u_shsr_partner.req_drive <= 1'b0;
        cyc(4);
        u_shsr_partner.req_drive <= 1'b1;
        starts(12, 1);
        done_pulse();
        u_shsr_partner.req_drive <= 1'b0;
        u_shsr_partner.slave_select_n <= 1'b0;
        look(6);
        chk("bus error", 7'h1, bus_error);
        cyc(1);
        u_shsr_partner.slave_select_n <= 1'b1;
        look(8);
        chk("bus error", 7'h1, bus_error);
        cyc(1);
        bus_error_clear <= 1'b1;
        cyc(1);
        bus_error_clear <= 1'b0;
        look(4);
        chk("bus error", 7'h0, bus_error);
    endtask
    task automatic t_resets;
        for (int i = 0; i < 2; i++) begin
            cyc(1);
            mode_master <= 1'b0;
            u_shsr_partner.slave_select_n <= 1'b0;
            soft_reset <= (i == 0);
            port_reset <= (i == 1);
            look(3);
            chk("request oe", 7'h1, host_request_n_oe_n);
            chk("miso oe", 7'h1, miso_oe_n);
            cyc(1);
            soft_reset <= 1'b0;
            port_reset <= 1'b0;
        end
    endtask
    task automatic t_addr;
        cyc(1);
        mode_i2c <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            cyc(1);
            {i2c_addr_strap_upper, i2c_addr_strap_lower} <= 2'(i);
            look(2);
            chk("strap bits", 7'(i), {own_slave_addr[2], own_slave_addr[0]});
        end
    endtask
    task automatic tally_and_finish;
        if (fails == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        look(2);
        chk("request oe", 7'h1, host_request_n_oe_n);
        chk("miso oe", 7'h1, miso_oe_n);
        cyc(3);
        reset <= 1'b0;
        cyc(3);
        t_slave();
        t_master();
        t_resets();
        t_addr();
        tally_and_finish();
    end
endmodule // shsr_pin_ctrl_tb
`default_nettype wire
